// ---- common/lpms_pkg.sv ----
package lpms_pkg;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [7:0]  LPMS_OFS_CTRL    = 8'h00;
  localparam logic [7:0]  LPMS_OFS_STATUS  = 8'h04;
  localparam logic [31:0] LPMS_CTRL_RESET  = 32'h0000_0000;
  localparam logic [31:0] LPMS_STAT_RESET  = 32'h0000_0000;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int LPMS_CTRL_LPDS_BIT   = 0;   // regulator_lowpower_select
  localparam int LPMS_CTRL_PDDS_BIT   = 1;   // powerdown_select
  localparam int LPMS_CTRL_WUCLR_BIT  = 2;   // wakeup flag clear, write 1
  localparam int LPMS_CTRL_SBCLR_BIT  = 3;   // standby_flag_clear, write 1
  localparam int LPMS_CTRL_PVDEN_BIT  = 4;
  localparam int LPMS_CTRL_PLSEL_LSB  = 5;
  localparam int LPMS_CTRL_PLSEL_MSB  = 7;
  localparam int LPMS_CTRL_BPWEN_BIT  = 8;
  localparam int LPMS_STAT_WUE_BIT    = 0;   // wakeup_event_flag
  localparam int LPMS_STAT_SB_BIT     = 1;   // standby_entered_flag
  localparam int LPMS_STAT_PVDO_BIT   = 2;
  localparam int LPMS_STAT_WKEN_BIT   = 8;   // wakeup_pin enable

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int LPMS_CLK_PERIOD_NS   = 10;
  localparam int LPMS_HSI_START_NS    = 1000;
  localparam int LPMS_REG_RECOVER_NS  = 1000;
  localparam int LPMS_CHIP_RESET_NS   = 1000;
  localparam int LPMS_WUCLR_DELAY     = 2;

  // least times round up to whole cycles, never below one
  function automatic int lpms_ns_to_cycles(input int ns);
    int c;
    c = (ns + LPMS_CLK_PERIOD_NS - 1) / LPMS_CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int LPMS_STOP_WAKE_CYCLES = lpms_ns_to_cycles(LPMS_HSI_START_NS) +
                                         lpms_ns_to_cycles(LPMS_REG_RECOVER_NS);
  localparam int LPMS_CHIP_RESET_CYCLES = lpms_ns_to_cycles(LPMS_CHIP_RESET_NS);
  localparam int LPMS_CNT_W = 12;

  // ****************************************************************
  // sequencer states
  // ****************************************************************
  typedef enum logic [2:0] {
    LPMS_RUN,
    LPMS_SLEEP,
    LPMS_STOP,
    LPMS_STOP_WAKE,
    LPMS_STANDBY,
    LPMS_STBY_RESET
  } lpms_state_t;

endpackage

// ---- hw/lpms_sync.sv ----
`timescale 1ns/1ns
module lpms_sync
  import lpms_pkg::*;
#(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         i_sys_clk,
  input  wire logic         i_reset_n,
  // asynchronous levels in, synchronised levels out
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  // two stages; first stage feeds only the second
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= i_async;
      sync_ff <= meta_ff;
    end
  end

  assign o_sync = sync_ff;

endmodule

// ---- hw/lpms_sequencer.sv ----
`timescale 1ns/1ns
// What this block does
// - With exit-sleep bit clear, a wait instruction enters sleep at once.
// - With exit-sleep bit set, sleep is entered right after handler return.
// - Wait-for-interrupt entries end on an interrupt, wait-for-event entries on an event.
// - Sleep halts only the core; peripherals run, state kept, no wake delay.
// - Interrupt wake services the interrupt first; event wake resumes after the wait.
// - Deep sleep set, powerdown select clear: wait instruction enters stop at once.
// - In stop the regulator follows the regulator low-power select bit.
// - Stop halts core and peripherals while state is kept.
// - Stop wake delay is oscillator start-up plus regulator recovery time.
// - Deep sleep, powerdown set, wake flag clear: wait instruction enters standby.
// - Standby exits on wake pin rise, alarm, tamper, reset pin or watchdog.
// - Standby stops core and peripherals and powers the domain off; only the control register is lost.
// - Standby exit costs one chip reset period, then restart from reset.
// - Control register clears on standby wake; status register keeps its value.
// - Standby flag sets on standby entry; writing clear bit 1 clears it.
// - Wake flag sets on a wake pin event or an alarm wake event.
module lpms_sequencer
  import lpms_pkg::*;
(
  // clock and reset
  input  wire logic        i_sys_clk,
  input  wire logic        i_reset_n,
  // register port
  input  wire logic        i_reg_sel,
  input  wire logic        i_reg_wr,
  input  wire logic [7:0]  i_reg_addr,
  input  wire logic [31:0] i_reg_wdata,
  output logic      [31:0] o_reg_rdata,
  // core side, same clock
  input  wire logic        i_wfi,
  input  wire logic        i_wfe,
  input  wire logic        i_deep_sleep_select,
  input  wire logic        i_sleep_on_handler_exit,
  input  wire logic        i_handler_return,
  input  wire logic        i_irq_pending,
  input  wire logic        i_event,
  // asynchronous wake sources
  input  wire logic        i_wakeup_pin,
  input  wire logic        i_rtc_alarm,
  input  wire logic        i_tamper_event,
  input  wire logic        i_external_reset_pin_n,
  input  wire logic        i_independent_watchdog,
  // power and clock controls
  output logic             o_core_halt,
  output logic             o_periph_halt,
  output logic             o_regulator_lowpower,
  output logic             o_domain_power_off,
  output logic             o_fast_osc_off,
  output logic             o_chip_reset,
  // resume indications
  output logic             o_resume_irq,
  output logic             o_resume_next,
  output logic             o_restart_from_reset
);

  // ****************************************************************
  // wake source synchronisers
  // ****************************************************************
  logic [4:0] src_sync;
  logic [4:0] src_dly_ff;

  lpms_sync #(.W(5)) u_sync (
    .i_sys_clk (i_sys_clk),
    .i_reset_n (i_reset_n),
    .i_async   ({i_independent_watchdog, ~i_external_reset_pin_n, i_tamper_event, i_rtc_alarm, i_wakeup_pin}),
    .o_sync    (src_sync)
  );

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) src_dly_ff <= '0;
    else            src_dly_ff <= src_sync;
  end

  // rising edges taken from the second stage only
  wire [4:0] src_rise = src_sync & ~src_dly_ff;

  // ****************************************************************
  // registers
  // ****************************************************************
  logic              lpds_ff, pdds_ff, pvden_ff, bpwen_ff;
  logic [2:0]        plsel_ff;
  logic              wue_ff, sb_ff, wken_ff;
  logic [1:0]        wuclr_cnt_ff;
  logic [31:0]       rdata_ff;
  lpms_state_t       state_ff, nxt_state;
  logic [LPMS_CNT_W-1:0] cnt_ff, nxt_cnt;
  logic              by_irq_ff, nxt_by_irq;
  logic              evt_pend_ff;
  logic              res_irq_ff, res_next_ff, restart_ff;
  logic              nxt_res_irq, nxt_res_next, nxt_restart;

  wire wr_ctrl  = i_reg_sel & i_reg_wr & (i_reg_addr == LPMS_OFS_CTRL);
  wire wr_stat  = i_reg_sel & i_reg_wr & (i_reg_addr == LPMS_OFS_STATUS);
  wire rd_any   = i_reg_sel & ~i_reg_wr;

  wire pin_event   = src_rise[0] & wken_ff;
  wire alarm_event = src_rise[1];
  wire wue_set     = pin_event | alarm_event;
  wire wuclr_fire  = (wuclr_cnt_ff == 2'(1));
  wire stby_wake   = pin_event | alarm_event | src_rise[2] | src_rise[3] | src_rise[4];
  wire wake_done   = (state_ff == LPMS_STBY_RESET) && (cnt_ff == '0);

  // control register; standby wake clears it, status is left alone
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      lpds_ff  <= LPMS_CTRL_RESET[LPMS_CTRL_LPDS_BIT];
      pdds_ff  <= LPMS_CTRL_RESET[LPMS_CTRL_PDDS_BIT];
      pvden_ff <= LPMS_CTRL_RESET[LPMS_CTRL_PVDEN_BIT];
      plsel_ff <= LPMS_CTRL_RESET[LPMS_CTRL_PLSEL_MSB:LPMS_CTRL_PLSEL_LSB];
      bpwen_ff <= LPMS_CTRL_RESET[LPMS_CTRL_BPWEN_BIT];
    end else if (wake_done) begin
      lpds_ff  <= LPMS_CTRL_RESET[LPMS_CTRL_LPDS_BIT];
      pdds_ff  <= LPMS_CTRL_RESET[LPMS_CTRL_PDDS_BIT];
      pvden_ff <= LPMS_CTRL_RESET[LPMS_CTRL_PVDEN_BIT];
      plsel_ff <= LPMS_CTRL_RESET[LPMS_CTRL_PLSEL_MSB:LPMS_CTRL_PLSEL_LSB];
      bpwen_ff <= LPMS_CTRL_RESET[LPMS_CTRL_BPWEN_BIT];
    end else if (wr_ctrl) begin
      lpds_ff  <= i_reg_wdata[LPMS_CTRL_LPDS_BIT];
      pdds_ff  <= i_reg_wdata[LPMS_CTRL_PDDS_BIT];
      pvden_ff <= i_reg_wdata[LPMS_CTRL_PVDEN_BIT];
      plsel_ff <= i_reg_wdata[LPMS_CTRL_PLSEL_MSB:LPMS_CTRL_PLSEL_LSB];
      bpwen_ff <= i_reg_wdata[LPMS_CTRL_BPWEN_BIT];
    end
  end

  // wake flag clear takes effect two clocks after the write
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n)
      wuclr_cnt_ff <= '0;
    else if (wr_ctrl && i_reg_wdata[LPMS_CTRL_WUCLR_BIT])
      wuclr_cnt_ff <= 2'(LPMS_WUCLR_DELAY);
    else if (wuclr_cnt_ff != '0)
      wuclr_cnt_ff <= wuclr_cnt_ff - 2'(1);
  end

  // status flags; a set in the clearing cycle wins
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wue_ff  <= LPMS_STAT_RESET[LPMS_STAT_WUE_BIT];
      sb_ff   <= LPMS_STAT_RESET[LPMS_STAT_SB_BIT];
      wken_ff <= LPMS_STAT_RESET[LPMS_STAT_WKEN_BIT];
    end else begin
      if (wue_set)
        wue_ff <= 1'b1;
      else if (wuclr_fire)
        wue_ff <= 1'b0;
      if (nxt_state == LPMS_STANDBY && state_ff != LPMS_STANDBY)
        sb_ff <= 1'b1;
      else if (wr_ctrl && i_reg_wdata[LPMS_CTRL_SBCLR_BIT])
        sb_ff <= 1'b0;
      if (wr_stat)
        wken_ff <= i_reg_wdata[LPMS_STAT_WKEN_BIT];
    end
  end

  // read data, unmapped offsets read zero
  wire [31:0] ctrl_view = {23'h0, bpwen_ff, plsel_ff, pvden_ff, 2'b00, pdds_ff, lpds_ff};
  wire [31:0] stat_view = {23'h0, wken_ff, 5'h00, 1'b0, sb_ff, wue_ff};
  wire [31:0] rd_mux    = (i_reg_addr == LPMS_OFS_CTRL)   ? ctrl_view :
                          (i_reg_addr == LPMS_OFS_STATUS) ? stat_view : 32'h0000_0000;

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n)  rdata_ff <= '0;
    else if (rd_any) rdata_ff <= rd_mux;
  end

  // ****************************************************************
  // sequencer
  // ****************************************************************
  // an event that ends a wfe entry is used up, else the next wfe would skip
  wire evt_used = ~by_irq_ff & i_event & ((state_ff == LPMS_SLEEP) | (state_ff == LPMS_STOP));

  // event latch stands in for the core's event register
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n)
      evt_pend_ff <= 1'b0;
    else if (i_event && !evt_used)
      evt_pend_ff <= 1'b1;
    else if (i_wfe && state_ff == LPMS_RUN)
      evt_pend_ff <= 1'b0;
  end

  wire wait_req   = i_wfi | i_wfe;
  wire exit_req   = i_sleep_on_handler_exit & i_handler_return;
  wire enter_req  = (wait_req & ~i_sleep_on_handler_exit) | exit_req;
  wire pend_wake  = (i_wfe & (evt_pend_ff | i_event)) |
                    ((i_wfi | exit_req) & i_irq_pending);
  wire to_stop    = i_deep_sleep_select & ~pdds_ff;
  wire to_stby    = i_deep_sleep_select & pdds_ff & ~wue_ff;
  wire stby_block = i_deep_sleep_select & pdds_ff & wue_ff;
  wire wake_irq   = by_irq_ff & i_irq_pending;
  wire wake_evt   = ~by_irq_ff & i_event;

  always_comb begin
    nxt_state    = state_ff;
    nxt_cnt      = cnt_ff;
    nxt_by_irq   = by_irq_ff;
    nxt_res_irq  = 1'b0;
    nxt_res_next = 1'b0;
    nxt_restart  = 1'b0;
    case (state_ff)
      LPMS_RUN: begin
        if (enter_req && !pend_wake && !stby_block) begin
          nxt_by_irq = ~i_wfe | exit_req;
          if (to_stby)
            nxt_state = LPMS_STANDBY;
          else if (to_stop)
            nxt_state = LPMS_STOP;
          else
            nxt_state = LPMS_SLEEP;
        end
      end
      LPMS_SLEEP: begin
        if (wake_irq || wake_evt) begin
          nxt_state    = LPMS_RUN;
          nxt_res_irq  = by_irq_ff;
          nxt_res_next = ~by_irq_ff;
        end
      end
      LPMS_STOP: begin
        if (wake_irq || wake_evt) begin
          nxt_state = LPMS_STOP_WAKE;
          nxt_cnt   = LPMS_CNT_W'(LPMS_STOP_WAKE_CYCLES - 1);
        end
      end
      LPMS_STOP_WAKE: begin
        if (cnt_ff == '0) begin
          nxt_state    = LPMS_RUN;
          nxt_res_irq  = by_irq_ff;
          nxt_res_next = ~by_irq_ff;
        end else begin
          nxt_cnt = cnt_ff - LPMS_CNT_W'(1);
        end
      end
      LPMS_STANDBY: begin
        if (stby_wake) begin
          nxt_state = LPMS_STBY_RESET;
          nxt_cnt   = LPMS_CNT_W'(LPMS_CHIP_RESET_CYCLES - 1);
        end
      end
      LPMS_STBY_RESET: begin
        if (cnt_ff == '0) begin
          nxt_state   = LPMS_RUN;
          nxt_restart = 1'b1;
        end else begin
          nxt_cnt = cnt_ff - LPMS_CNT_W'(1);
        end
      end
      default: nxt_state = LPMS_RUN;
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_ff    <= LPMS_RUN;
      cnt_ff      <= '0;
      by_irq_ff   <= 1'b0;
      res_irq_ff  <= 1'b0;
      res_next_ff <= 1'b0;
      restart_ff  <= 1'b0;
    end else begin
      state_ff    <= nxt_state;
      cnt_ff      <= nxt_cnt;
      by_irq_ff   <= nxt_by_irq;
      res_irq_ff  <= nxt_res_irq;
      res_next_ff <= nxt_res_next;
      restart_ff  <= nxt_restart;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  // stop wake keeps everything halted until clocks and regulator are back
  wire in_stop = (state_ff == LPMS_STOP) || (state_ff == LPMS_STOP_WAKE);
  wire in_stby = (state_ff == LPMS_STANDBY) || (state_ff == LPMS_STBY_RESET);

  assign o_reg_rdata          = rdata_ff;
  assign o_core_halt          = (state_ff != LPMS_RUN);
  assign o_periph_halt        = in_stop | in_stby;
  assign o_regulator_lowpower = (state_ff == LPMS_STOP) & lpds_ff;
  assign o_domain_power_off   = in_stby;
  assign o_fast_osc_off       = (state_ff == LPMS_STOP) | (state_ff == LPMS_STANDBY);
  assign o_chip_reset         = (state_ff == LPMS_STBY_RESET);
  assign o_resume_irq         = res_irq_ff;
  assign o_resume_next        = res_next_ff;
  assign o_restart_from_reset = restart_ff;

endmodule

// ---- testbench/lpms_chk.sv ----
`timescale 1ns/1ns
module lpms_chk
  import lpms_pkg::*;
(
  // clock, reset and register port
  input wire logic        i_sys_clk,
  input wire logic        i_reset_n,
  input wire logic        i_reg_sel,
  input wire logic        i_reg_wr,
  input wire logic [7:0]  i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  // core side
  input wire logic        i_wfi,
  input wire logic        i_deep_sleep_select,
  input wire logic        i_sleep_on_handler_exit,
  input wire logic        i_irq_pending,
  // power controls and resume
  input wire logic        o_core_halt,
  input wire logic        o_periph_halt,
  input wire logic        o_regulator_lowpower,
  input wire logic        o_domain_power_off,
  input wire logic        o_fast_osc_off,
  input wire logic        o_chip_reset,
  input wire logic        o_resume_irq,
  input wire logic        o_resume_next,
  input wire logic        o_restart_from_reset
);
  logic [1:0]  mode_ff;
  logic [11:0] wcnt_ff;
  logic [11:0] rcnt_ff;
  // stop-wake state is the only one with peripherals halted, oscillator on and domain powered
  wire         waking = o_periph_halt & ~o_fast_osc_off & ~o_domain_power_off;
  wire         ctrl_wr = i_reg_sel & i_reg_wr & (i_reg_addr == LPMS_OFS_CTRL);

  // shadow of the mode bits; long waits counted here, too long to unroll
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      mode_ff <= 2'h0;
      wcnt_ff <= 12'h000;
      rcnt_ff <= 12'h000;
    end else begin
      mode_ff <= o_restart_from_reset ? 2'h0 : ctrl_wr ? i_reg_wdata[1:0] : mode_ff;
      wcnt_ff <= waking ? wcnt_ff + 12'h001 : 12'h000;
      rcnt_ff <= o_chip_reset ? rcnt_ff + 12'h001 : 12'h000;
    end
  end

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_reset_n);

  property p_sleep_enter;
    i_wfi && !i_deep_sleep_select && !i_sleep_on_handler_exit && !i_irq_pending && !o_core_halt
      |=> o_core_halt && !o_periph_halt;
  endproperty
  a_sleep_enter: assert property (p_sleep_enter) else $error("sleep entry wrong");
  property p_stop_enter;
    i_wfi && i_deep_sleep_select && !mode_ff[1] && !i_sleep_on_handler_exit && !i_irq_pending
      && !o_core_halt |=> o_core_halt && o_periph_halt && !o_domain_power_off;
  endproperty
  a_stop_enter: assert property (p_stop_enter) else $error("stop entry wrong");
  property p_stby_off;
    o_domain_power_off |-> o_core_halt && o_periph_halt;
  endproperty
  a_stby_off: assert property (p_stby_off) else $error("standby not halted");
  property p_reg_lp;
    o_periph_halt && o_fast_osc_off && !o_domain_power_off |-> o_regulator_lowpower == mode_ff[0];
  endproperty
  a_reg_lp: assert property (p_reg_lp) else $error("regulator mode wrong");
  property p_stop_wake;
    $fell(o_core_halt) && $past(waking) |-> wcnt_ff == 12'(LPMS_STOP_WAKE_CYCLES);
  endproperty
  a_stop_wake: assert property (p_stop_wake) else $error("stop wake delay wrong");
  property p_stby_wake;
    $fell(o_chip_reset) |-> rcnt_ff == 12'(LPMS_CHIP_RESET_CYCLES) && o_restart_from_reset;
  endproperty
  a_stby_wake: assert property (p_stby_wake) else $error("standby reset period wrong");
  property p_resume;
    o_resume_irq |-> !o_resume_next && !o_core_halt;
  endproperty
  a_resume: assert property (p_resume) else $error("resume kind wrong");
  property p_skip;
    i_wfi && i_irq_pending && !o_core_halt |=> !o_core_halt;
  endproperty
  a_skip: assert property (p_skip) else $error("entered with wake pending");
endmodule

bind lpms_sequencer lpms_chk u_chk (.*);

// ---- testbench/lpms_core_model.sv ----
`timescale 1ns/1ns
module lpms_core_model (
  // clock and sequencer answer
  input  wire logic i_sys_clk,
  input  wire logic i_resume_irq,
  // core requests and levels
  output logic      o_wfi,
  output logic      o_wfe,
  output logic      o_ret,
  output logic      o_irq,
  output logic      o_evt
);
  initial begin
    {o_wfi, o_wfe, o_ret, o_irq, o_evt} = 5'h00;
  end
  // the handler acknowledges the interrupt once the core resumes into it
  always @(posedge i_sys_clk) if (i_resume_irq) o_irq <= 1'b0;
  // one-cycle wait instruction, wfe when ev is set
  task automatic pulse_wait(input logic ev);
    @(posedge i_sys_clk);
    if (ev) o_wfe <= 1'b1; else o_wfi <= 1'b1;
    @(posedge i_sys_clk);
    o_wfe <= 1'b0;
    o_wfi <= 1'b0;
  endtask
  task automatic pulse_ret;
    @(posedge i_sys_clk);
    o_ret <= 1'b1;
    @(posedge i_sys_clk);
    o_ret <= 1'b0;
  endtask
  task automatic pulse_evt;
    @(posedge i_sys_clk);
    o_evt <= 1'b1;
    @(posedge i_sys_clk);
    o_evt <= 1'b0;
  endtask
  // prompt or slow interrupt, level until serviced
  task automatic set_irq(input int dly, input logic v);
    repeat (dly + 1) @(posedge i_sys_clk);
    o_irq <= v;
  endtask
endmodule

// ---- testbench/lpms_sequencer_tb.sv ----
`timescale 1ns/1ns
`define CK(n,e,g) begin tests_run++; if ((g) !== (e)) begin fail_count++; \
  $display("wrong value %s exp %h got %h", n, e, g); end end
`define WT(s,l) n = 0; while ((s) !== 1'b1 && n < (l)) begin @(negedge i_sys_clk); n++; end
module lpms_sequencer_tb;
  import lpms_pkg::*;
  // ****************************************************************
  // signals
  // ****************************************************************
  logic        i_sys_clk, i_reset_n, i_reg_sel, i_reg_wr;
  logic [7:0]  i_reg_addr;
  logic [31:0] i_reg_wdata;
  logic [4:0]  src;
  wire  [31:0] o_reg_rdata;
  logic        i_deep_sleep_select, i_sleep_on_handler_exit;
  wire         i_wfi, i_wfe, i_handler_return;
  wire         i_irq_pending, i_event;
  wire         o_core_halt, o_periph_halt, o_regulator_lowpower, o_domain_power_off;
  wire         o_fast_osc_off, o_chip_reset, o_resume_irq, o_resume_next, o_restart_from_reset;
  wire         i_wakeup_pin = src[0];
  wire         i_rtc_alarm = src[1];
  wire         i_tamper_event = src[2];
  wire         i_external_reset_pin_n = ~src[3];
  wire         i_independent_watchdog = src[4];
  int          fail_count, tests_run, cyc, n;

  lpms_sequencer uut (.*);
  lpms_core_model core (.i_sys_clk(i_sys_clk), .i_resume_irq(o_resume_irq), .o_wfi(i_wfi),
    .o_wfe(i_wfe), .o_ret(i_handler_return), .o_irq(i_irq_pending), .o_evt(i_event));

  // ****************************************************************
  // register access
  // ****************************************************************
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_sys_clk);
    {i_reg_sel, i_reg_wr, i_reg_addr, i_reg_wdata} <= {2'h3, a, d};
    @(posedge i_sys_clk);
    {i_reg_sel, i_reg_wr} <= 2'h0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_sys_clk);
    {i_reg_sel, i_reg_wr, i_reg_addr} <= {2'h2, a};
    @(posedge i_sys_clk);
    i_reg_sel <= 1'b0;
    @(negedge i_sys_clk);
    d = o_reg_rdata;
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_regs;
    logic [31:0] d;
    rd(8'h00, d); `CK("ctrl reset", LPMS_CTRL_RESET, d)
    rd(8'h04, d); `CK("status reset", LPMS_STAT_RESET, d)
    wr(8'h00, 32'hffff_ffff); rd(8'h00, d); `CK("ctrl rw", 32'h0000_01f3, d)
    wr(8'h04, 32'hffff_ffff); rd(8'h04, d); `CK("status rw", 32'h0000_0100, d)
    wr(8'h08, 32'hffff_ffff); rd(8'h08, d); `CK("unmapped", 32'h0000_0000, d)
    wr(8'h00, 32'h0);
    $display("registers done");
  endtask
  task automatic t_sleep;
    core.pulse_wait(1'b0);
    @(negedge i_sys_clk); `CK("sleep halt", 1'b1, o_core_halt)
    `CK("sleep periph", 1'b0, o_periph_halt)
    core.set_irq(3, 1'b1);
    `WT(o_resume_irq, 9) `CK("irq resume", 1'b1, o_resume_irq)
    core.pulse_wait(1'b1);
    core.set_irq(1, 1'b1);
    // an interrupt alone must not end a wfe entry
    repeat (5) @(negedge i_sys_clk); `CK("wfe held", 1'b1, o_core_halt)
    core.pulse_evt;
    `WT(o_resume_next, 9) `CK("event resume", 1'b1, o_resume_next)
    `CK("no delay", 1'b0, o_core_halt)
    core.pulse_wait(1'b0);
    @(negedge i_sys_clk); `CK("pending skip", 1'b0, o_core_halt)
    core.set_irq(0, 1'b0);
    $display("sleep done");
  endtask
  task automatic t_exit;
    @(posedge i_sys_clk); i_sleep_on_handler_exit <= 1'b1;
    core.pulse_ret;
    @(negedge i_sys_clk); `CK("exit sleep", 1'b1, o_core_halt)
    core.set_irq(2, 1'b1);
    `WT(o_resume_irq, 9) `CK("exit wake", 1'b1, o_resume_irq)
    @(posedge i_sys_clk); i_sleep_on_handler_exit <= 1'b0;
    $display("exit sleep done");
  endtask
  task automatic t_stop;
    for (int j = 0; j < 2; j++) begin
      wr(8'h00, 32'(j));
      @(posedge i_sys_clk); i_deep_sleep_select <= 1'b1;
      // second pass enters by wfe and must leave on an event
      core.pulse_wait(j[0]);
      @(negedge i_sys_clk); `CK("stop periph", 1'b1, o_periph_halt)
      `CK("stop reg", j[0], o_regulator_lowpower)
      `CK("stop osc", 1'b1, o_fast_osc_off)
      if (j == 0)
        core.set_irq(1, 1'b1);
      else
        core.pulse_evt;
      repeat (LPMS_STOP_WAKE_CYCLES - 2) @(negedge i_sys_clk);
      `CK("stop wake busy", 1'b1, o_core_halt)
      `WT((j == 0) ? o_resume_irq : o_resume_next, 20)
      `CK("stop resume", 1'b1, (j == 0) ? o_resume_irq : o_resume_next)
      @(posedge i_sys_clk); i_deep_sleep_select <= 1'b0;
    end
    wr(8'h00, 32'h0);
    $display("stop done");
  endtask
  task automatic t_stby;
    logic [31:0] d;
    for (int i = 0; i < 5; i++) begin
      wr(8'h00, 32'h6);
      repeat (3) @(posedge i_sys_clk);
      i_deep_sleep_select <= 1'b1;
      core.pulse_wait(1'b0);
      @(negedge i_sys_clk); `CK("standby off", 1'b1, o_domain_power_off)
      @(posedge i_sys_clk); i_deep_sleep_select <= 1'b0; src <= 5'h01 << i;
      repeat (4) @(posedge i_sys_clk);
      src <= 5'h00;
      `WT(o_restart_from_reset, LPMS_CHIP_RESET_CYCLES + 20)
      `CK("restart", 1'b1, o_restart_from_reset)
      rd(8'h00, d); `CK("ctrl cleared", 32'h0, d)
      rd(8'h04, d); `CK("standby flag", 2'h3, {d[8], d[1]})
    end
    $display("standby done");
  endtask
  task automatic t_flags;
    logic [31:0] d;
    @(posedge i_sys_clk); src <= 5'h02;
    repeat (4) @(posedge i_sys_clk);
    src <= 5'h00;
    rd(8'h04, d); `CK("wake flag", 1'b1, d[0])
    wr(8'h00, 32'h2);
    @(posedge i_sys_clk); i_deep_sleep_select <= 1'b1;
    core.pulse_wait(1'b0);
    @(negedge i_sys_clk); `CK("flag skip", 1'b0, o_core_halt)
    @(posedge i_sys_clk); i_deep_sleep_select <= 1'b0;
    wr(8'h00, 32'hc);
    repeat (3) @(posedge i_sys_clk);
    rd(8'h04, d); `CK("flags cleared", 32'h0000_0100, d)
    $display("flags done");
  endtask

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ****************************************************************
  // clock, watchdog on the run, main sequence
  // ****************************************************************
  initial begin
    i_sys_clk = 1'b0;
    forever #5 i_sys_clk = ~i_sys_clk; // run clock kept at full speed; slowing it is software's choice
  end
  // the whole run needs a little over a thousand cycles; far beyond that is a hang
  always @(posedge i_sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      print_verdict;
    end
  end
  initial begin
    {i_reset_n, i_reg_sel, i_reg_wr, i_reg_addr, i_reg_wdata, src} = '0;
    {i_deep_sleep_select, i_sleep_on_handler_exit} = 2'h0;
    repeat (8) @(posedge i_sys_clk);
    i_reset_n <= 1'b1;
    t_regs;
    t_sleep;
    t_exit;
    t_stop;
    t_stby;
    t_flags;
    print_verdict;
  end
endmodule
